// ===== logic/eec_regs.svh
`ifndef EEC_REGS_SVH
`define EEC_REGS_SVH

// Register byte offsets
`define EEC_OFS_MODE 8'h00
`define EEC_OFS_EDGE 8'h04
`define EEC_OFS_RELOAD 8'h08
`define EEC_OFS_COUNT 8'h0c
`define EEC_OFS_TRIG 8'h10
`define EEC_OFS_STATUS 8'h14
`define EEC_OFS_OUTCTL 8'h18

// Reset values
`define EEC_RST_MODE 16'h0000
`define EEC_RST_EDGE 2'h0
`define EEC_RST_RELOAD 16'h0000
`define EEC_RST_COUNT 16'h0000

// Mode register fields
`define EEC_MODE_CKS_HI 15
`define EEC_MODE_CKS_LO 14
`define EEC_MODE_CCS 12
`define EEC_MODE_MAS 11
`define EEC_MODE_MD_HI 4
`define EEC_MODE_MD_LO 1
`define EEC_MODE_MD0 0

// Trigger and status bits
`define EEC_TRIG_START 0
`define EEC_TRIG_STOP 1
`define EEC_STAT_EN 0

// Edge select codes
`define EEC_EDGE_FALL 2'h0
`define EEC_EDGE_RISE 2'h1
`define EEC_EDGE_BOTH 2'h2

// Bus responses
`define EEC_RESP_OKAY 2'h0
`define EEC_RESP_SLVERR 2'h2

`endif

// ===== logic/eec_pkg.sv
package eec_pkg;
  // Channel run state, Gray along idle to count
  typedef enum logic [0:0] {
    EEC_IDLE = 1'b0,
    EEC_COUNT = 1'b1
  } eec_state_t;

  // Bus response code
  typedef logic [1:0] eec_resp_t;
endpackage : eec_pkg

// ===== logic/eec_channel.sv
`timescale 1ns/1ps
`include "eec_regs.svh"

// Contract
// - Start write sets channel enable status
// - Start trigger bit clears itself
// - Start copies reload into down counter
// - Each valid edge decrements by one
// - Counter holds between valid edges
// - At zero: interrupt, reload, keep counting
// - Edge select: fall, rise, both
// - Reload plus one edges per interrupt
// - Stop write clears enable, freezes counter
// - Stop trigger bit clears itself
// - Stopped counter ignores event edges
// - Start while counting forces reload
// - New reload used at next load
// - Reload zero: interrupt every edge
// - Count clock source selects event edges
// - Start interrupt bit off: no start interrupt
// - Clock select picks one of four clocks
// - Counter readable without disturbing count
// - Output only from direct output control
module eec_channel (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output eec_pkg::eec_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output eec_pkg::eec_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Prescaled operation clock ticks
  input wire logic [3:0] op_clk_tick,
  // External event
  input wire logic event_input,
  // Channel outputs
  output logic channel_irq,
  output logic channel_output,
  output logic channel_enable_status
);
  import eec_pkg::*;
  // Register storage
  logic [15:0] mode_reg; // Channel mode register
  logic [1:0] edge_reg; // Edge select field
  logic [15:0] reload_reg; // Reload value
  logic [15:0] count_reg; // Down counter
  logic outlvl_reg; // Direct output level
  eec_state_t state_reg; // Run state
  logic irq_reg; // Interrupt pulse
  // Write channel holding
  logic aw_full_reg;
  logic [7:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  eec_resp_t bresp_reg;
  // Read channel holding
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  eec_resp_t rresp_reg;
  // Event sampling
  logic samp_reg; // Input sampled on operation tick
  logic prev_reg; // Previous sample
  logic op_tick; // Selected operation clock tick
  logic rise_det; // Rising edge seen
  logic fall_det; // Falling edge seen
  logic valid_edge; // Edge matching select
  logic count_tick; // Count clock
  // Decoded writes
  logic wr_fire; // Write performed this cycle
  logic wr_map; // Write address mapped
  logic start_cmd; // Start trigger written
  logic stop_cmd; // Stop trigger written
  logic [15:0] wr_data16; // Byte-masked 16-bit write value
  logic [15:0] wr_old16; // Old value of addressed register
  // Field views
  logic [1:0] clock_select;
  logic count_clock_source;
  logic start_irq_enable;
  assign clock_select = mode_reg[`EEC_MODE_CKS_HI:`EEC_MODE_CKS_LO];
  assign count_clock_source = mode_reg[`EEC_MODE_CCS];
  assign start_irq_enable = mode_reg[`EEC_MODE_MD0];
  // Handshake outputs
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign channel_irq = irq_reg;
  assign channel_output = outlvl_reg;
  assign channel_enable_status = (state_reg == EEC_COUNT);
  // Write performed once address and data are both held
  assign wr_fire = aw_full_reg && w_full_reg;
  assign start_cmd = wr_fire && (aw_addr_reg == `EEC_OFS_TRIG) && w_strb_reg[0]
    && w_data_reg[`EEC_TRIG_START];
  assign stop_cmd = wr_fire && (aw_addr_reg == `EEC_OFS_TRIG) && w_strb_reg[0]
    && w_data_reg[`EEC_TRIG_STOP];
  // Address map check for writes
  always_comb
  begin
    case (aw_addr_reg)
      `EEC_OFS_MODE, `EEC_OFS_EDGE, `EEC_OFS_RELOAD, `EEC_OFS_COUNT,
      `EEC_OFS_TRIG, `EEC_OFS_STATUS, `EEC_OFS_OUTCTL: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end
  // Old value for byte merging
  always_comb
  begin
    case (aw_addr_reg)
      `EEC_OFS_MODE: wr_old16 = mode_reg;
      `EEC_OFS_RELOAD: wr_old16 = reload_reg;
      default: wr_old16 = 16'h0000;
    endcase
  end
  // Byte lanes 0 and 1 merge into 16-bit registers
  assign wr_data16 = {w_strb_reg[1] ? w_data_reg[15:8] : wr_old16[15:8],
                      w_strb_reg[0] ? w_data_reg[7:0] : wr_old16[7:0]};
  // Write address capture
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (wr_fire)
      aw_full_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
    end
  end
  // Write data capture
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wr_fire)
      w_full_reg <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end
  // Write response
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `EEC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_map ? `EEC_RESP_OKAY : `EEC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end
  // Configuration registers; reload takes effect only at next load
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= `EEC_RST_MODE;
      edge_reg <= `EEC_RST_EDGE;
      reload_reg <= `EEC_RST_RELOAD;
      outlvl_reg <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (aw_addr_reg)
        `EEC_OFS_MODE: mode_reg <= wr_data16;
        `EEC_OFS_EDGE:
        begin
          if (w_strb_reg[0])
            edge_reg <= w_data_reg[1:0];
        end
        `EEC_OFS_RELOAD: reload_reg <= wr_data16;
        `EEC_OFS_OUTCTL:
        begin
          if (w_strb_reg[0])
            outlvl_reg <= w_data_reg[0];
        end
        default: ; // Read-only, trigger or unmapped: nothing stored
      endcase
    end
  end
  // Read path; counter read has no side effect
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `EEC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `EEC_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        `EEC_OFS_MODE: rdata_reg <= {16'h0000, mode_reg};
        `EEC_OFS_EDGE: rdata_reg <= {30'h0000_0000, edge_reg};
        `EEC_OFS_RELOAD: rdata_reg <= {16'h0000, reload_reg};
        `EEC_OFS_COUNT: rdata_reg <= {16'h0000, count_reg};
        `EEC_OFS_TRIG: rdata_reg <= 32'h0000_0000;
        `EEC_OFS_STATUS: rdata_reg <= {31'h0000_0000, channel_enable_status};
        `EEC_OFS_OUTCTL: rdata_reg <= {31'h0000_0000, outlvl_reg};
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `EEC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end
  // Operation clock selection
  assign op_tick = op_clk_tick[clock_select];
  // Event input sampled at operation clock rate
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else if (op_tick)
    begin
      samp_reg <= event_input;
      prev_reg <= samp_reg;
    end
  end
  // Edge detect, one pulse per sampled edge
  assign rise_det = op_tick && samp_reg && !prev_reg;
  assign fall_det = op_tick && !samp_reg && prev_reg;
  // Edge select decode
  always_comb
  begin
    case (edge_reg)
      `EEC_EDGE_FALL: valid_edge = fall_det;
      `EEC_EDGE_RISE: valid_edge = rise_det;
      `EEC_EDGE_BOTH: valid_edge = rise_det || fall_det;
      default: valid_edge = 1'b0;
    endcase
  end
  // Count clock: event edge, else operation clock
  assign count_tick = count_clock_source ? valid_edge : op_tick;
  // Run state; stop wins over a start in the same write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= EEC_IDLE;
    else
    begin
      case (state_reg)
        EEC_IDLE:
        begin
          if (start_cmd && !stop_cmd)
            state_reg <= EEC_COUNT;
        end
        EEC_COUNT:
        begin
          if (stop_cmd)
            state_reg <= EEC_IDLE;
        end
        default: state_reg <= EEC_IDLE;
      endcase
    end
  end
  // Down counter
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= `EEC_RST_COUNT;
    else if (stop_cmd)
      count_reg <= count_reg;
    else if (start_cmd)
      count_reg <= reload_reg;
    else if (state_reg == EEC_COUNT && count_tick)
    begin
      if (count_reg == 16'h0000)
        count_reg <= reload_reg;
      else
        count_reg <= count_reg - 16'h0001;
    end
  end
  // Interrupt pulse: at wrap, or at start when enabled
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else if (stop_cmd)
      irq_reg <= 1'b0;
    else if (start_cmd)
      irq_reg <= start_irq_enable;
    else
      irq_reg <= state_reg == EEC_COUNT && count_tick && count_reg == 16'h0000;
  end
  // Checks
  sequence s_plain_cycle;
    !start_cmd && !stop_cmd;
  endsequence
  sequence s_wrap;
    s_plain_cycle ##0 state_reg == EEC_COUNT && count_tick && count_reg == 16'h0000;
  endsequence
  property p_start_load;
    @(posedge clk_sys) disable iff (!rst_n)
    start_cmd && !stop_cmd |=> channel_enable_status && count_reg == $past(reload_reg);
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load");
  property p_stop_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
    stop_cmd |=> !channel_enable_status && count_reg == $past(count_reg);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("stop did not freeze");
  property p_decrement;
    @(posedge clk_sys) disable iff (!rst_n)
    s_plain_cycle ##0 channel_enable_status && count_tick && count_reg != 16'h0000
      |=> count_reg == $past(count_reg) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad decrement");
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    s_plain_cycle ##0 !count_tick |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without edge");
  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    s_wrap |=> channel_irq && count_reg == $past(reload_reg) && channel_enable_status;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no reload and interrupt at zero");
  property p_idle_ignore;
    @(posedge clk_sys) disable iff (!rst_n)
    !channel_enable_status && !start_cmd |=> $stable(count_reg) && !channel_irq;
  endproperty
  a_idle_ignore: assert property (p_idle_ignore) else $error("stopped counter moved");
  property p_irq_cause;
    @(posedge clk_sys) disable iff (!rst_n)
    channel_irq |-> $past(start_cmd && start_irq_enable && !stop_cmd) || $past(count_reg == 16'h0000);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");
  property p_rise_select;
    @(posedge clk_sys) disable iff (!rst_n)
    valid_edge && edge_reg == `EEC_EDGE_RISE |-> samp_reg && !prev_reg && op_tick;
  endproperty
  a_rise_select: assert property (p_rise_select) else $error("wrong edge counted");
  property p_trig_reads_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h04 |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read nonzero");
  property p_reload_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    s_plain_cycle ##0 channel_enable_status && reload_reg == 16'h0000 && count_reg == 16'h0000
      && count_tick |=> channel_irq ##0 count_reg == 16'h0000;
  endproperty
  a_reload_zero: assert property (p_reload_zero) else $error("zero reload misbehaves");
endmodule : eec_channel

// ===== verif/eec_pulse_src.sv
`timescale 1ns/1ps

// Event pulse source at the channel's event input
module eec_pulse_src (
  // Clock
  input wire logic clk_sys,
  // Event level to the channel
  output logic event_input
);
  // Cycles each level is held, long enough for the slowest tick
  int hold = 20;

  // Line rests low between pulses
  initial event_input = 1'b0;

  // Emit n whole pulses, rise then fall
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      event_input <= 1'b1;
      repeat (hold) @(posedge clk_sys);
      event_input <= 1'b0;
      repeat (hold) @(posedge clk_sys);
    end
  endtask : pulse
endmodule : eec_pulse_src

// ===== verif/eec_channel_tb_top.sv
`timescale 1ns/1ps
`include "eec_regs.svh"

module eec_channel_tb_top;
  import eec_pkg::*;
  // Clock, reset and tick divider
  logic clk_sys, rst_n;
  logic [3:0] tc;
  logic [3:0] tick;
  // Bus master signals
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, rdv;
  logic [3:0] ws;
  logic awv, wv, bry, arv, rry;
  logic awr, wrd, bv, arr, rv, irq, out, en, ev;
  eec_resp_t br, rr;
  logic [1:0] lr;
  // Tallies
  int failures, n_tests, irqs;
  // Event count mode, edge as count clock, no start irq
  localparam logic [15:0] MEVT = 16'h1006;

  eec_channel uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .op_clk_tick(tick), .event_input(ev), .channel_irq(irq),
    .channel_output(out), .channel_enable_status(en));

  eec_pulse_src src (.clk_sys(clk_sys), .event_input(ev));

  // Free running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Four prescaled ticks: every 2, 4, 8, 16 cycles
  always @(posedge clk_sys)
  begin
    tc <= tc + 4'h1;
    tick <= {tc == 4'hf, tc[2:0] == 3'h7, tc[1:0] == 2'h3, tc[0]};
  end

  // Count interrupt pulses
  always @(posedge clk_sys)
    if (irq === 1'b1) irqs <= irqs + 1;

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One write, response kept in lr
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int t;
    logic ah, wh, bh;
    t = 0;
    @(posedge clk_sys);
    awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ah = awv && (awr === 1'b1);
      wh = wv && (wrd === 1'b1);
      bh = (bv === 1'b1);
      lr = br;
      @(posedge clk_sys);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      t++;
    end while (!bh && t < 50);
    bry <= 1'b0;
    if (!bh)
    begin
      $display("[FAIL] bvalid expected 1 seen 0");
      failures++;
      report_and_stop;
    end
  endtask : wr

  // One read, data in rdv, response in lr
  task automatic rdr(input logic [7:0] a);
    int t;
    logic ah, bh;
    t = 0;
    @(posedge clk_sys);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ah = arv && (arr === 1'b1);
      bh = (rv === 1'b1);
      rdv = rdata;
      lr = rr;
      @(posedge clk_sys);
      if (ah) arv <= 1'b0;
      t++;
    end while (!bh && t < 50);
    rry <= 1'b0;
    if (!bh)
    begin
      $display("[FAIL] rvalid expected 1 seen 0");
      failures++;
      report_and_stop;
    end
  endtask : rdr

  // Read and compare
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(nm, e, rdv);
  endtask : rc

  // Configure and start the channel
  task automatic go(input logic [15:0] m, input logic [1:0] es, input logic [15:0] rl);
    wr(`EEC_OFS_MODE, {16'h0, m});
    wr(`EEC_OFS_EDGE, {30'h0, es});
    wr(`EEC_OFS_RELOAD, {16'h0, rl});
    wr(`EEC_OFS_TRIG, 32'h1);
  endtask : go

  // Reset values and unmapped place
  task automatic t_reset;
    rc("mode", `EEC_OFS_MODE, {16'h0, `EEC_RST_MODE});
    rc("edge", `EEC_OFS_EDGE, {30'h0, `EEC_RST_EDGE});
    rc("reload", `EEC_OFS_RELOAD, {16'h0, `EEC_RST_RELOAD});
    rc("count", `EEC_OFS_COUNT, {16'h0, `EEC_RST_COUNT});
    rc("status", `EEC_OFS_STATUS, 32'h0);
    rdr(8'h1c);
    chk("rresp", {30'h0, `EEC_RESP_SLVERR}, {30'h0, lr});
    chk("rdata", 32'h0, rdv);
    wr(8'h1c, 32'h1);
    chk("bresp", {30'h0, `EEC_RESP_SLVERR}, {30'h0, lr});
    // Byte lanes: only strobed lanes are written
    wr(`EEC_OFS_RELOAD, 32'h0000_ab12, 4'h1);
    rc("reload lane 0", `EEC_OFS_RELOAD, 32'h0000_0012);
    wr(`EEC_OFS_RELOAD, 32'h0000_cd00, 4'h2);
    rc("reload lane 1", `EEC_OFS_RELOAD, 32'h0000_cd12);
    wr(`EEC_OFS_EDGE, 32'h0000_0001, 4'he);
    rc("edge lane", `EEC_OFS_EDGE, 32'h0000_0000);
  endtask : t_reset

  // Start, count down, reload at zero
  task automatic t_count;
    int i0;
    i0 = irqs;
    go(MEVT, `EEC_EDGE_RISE, 16'h3);
    rc("status", `EEC_OFS_STATUS, 32'h1);
    rc("trig", `EEC_OFS_TRIG, 32'h0);
    rc("count", `EEC_OFS_COUNT, 32'h3);
    chk("irq at start", 32'(i0), 32'(irqs));
    src.pulse(1);
    rc("count", `EEC_OFS_COUNT, 32'h2);
    repeat (30) @(posedge clk_sys);
    rc("count", `EEC_OFS_COUNT, 32'h2);
    wr(`EEC_OFS_RELOAD, 32'h5);
    src.pulse(2);
    rc("count", `EEC_OFS_COUNT, 32'h0);
    chk("irq early", 32'(i0), 32'(irqs));
    src.pulse(1);
    chk("irq", 32'(i0 + 1), 32'(irqs));
    rc("count", `EEC_OFS_COUNT, 32'h5);
  endtask : t_count

  // Stop freezes, edges ignored, start reloads
  task automatic t_stop;
    int i0;
    i0 = irqs;
    wr(`EEC_OFS_TRIG, 32'h2);
    rc("status", `EEC_OFS_STATUS, 32'h0);
    rc("trig", `EEC_OFS_TRIG, 32'h0);
    chk("enable pin", 32'h0, {31'h0, en});
    src.pulse(2);
    rc("count", `EEC_OFS_COUNT, 32'h5);
    chk("irq stopped", 32'(i0), 32'(irqs));
    wr(`EEC_OFS_TRIG, 32'h1);
    rc("status", `EEC_OFS_STATUS, 32'h1);
    rc("count", `EEC_OFS_COUNT, 32'h5);
  endtask : t_stop

  // Start while counting reloads at once
  task automatic t_force;
    src.pulse(1);
    rc("count", `EEC_OFS_COUNT, 32'h4);
    wr(`EEC_OFS_RELOAD, 32'h7);
    rc("count", `EEC_OFS_COUNT, 32'h4);
    wr(`EEC_OFS_TRIG, 32'h1);
    rc("count", `EEC_OFS_COUNT, 32'h7);
    rc("status", `EEC_OFS_STATUS, 32'h1);
  endtask : t_force

  // Each edge code on one pulse
  task automatic t_edges;
    for (int c = 0; c < 3; c++)
    begin
      go(MEVT, c[1:0], 16'h9);
      src.pulse(1);
      rc("edge count", `EEC_OFS_COUNT, (c == 2) ? 32'h7 : 32'h8);
    end
  endtask : t_edges

  // Reload zero, both edges: irq per edge
  task automatic t_zero;
    int i0;
    i0 = irqs;
    go(MEVT, `EEC_EDGE_BOTH, 16'h0);
    src.pulse(2);
    chk("irq per edge", 32'(i0 + 4), 32'(irqs));
    rc("count", `EEC_OFS_COUNT, 32'h0);
  endtask : t_zero

  // Every operation clock choice samples the event
  task automatic t_cks;
    for (int k = 0; k < 4; k++)
    begin
      go({k[1:0], MEVT[13:0]}, `EEC_EDGE_RISE, 16'h9);
      src.pulse(1);
      rc("cks count", `EEC_OFS_COUNT, 32'h8);
    end
  endtask : t_cks

  // Output follows direct control only
  task automatic t_out;
    wr(`EEC_OFS_OUTCTL, 32'h1);
    chk("out set", 32'h1, {31'h0, out});
    src.pulse(2);
    chk("out kept", 32'h1, {31'h0, out});
    wr(`EEC_OFS_OUTCTL, 32'h0);
    chk("out clear", 32'h0, {31'h0, out});
  endtask : t_out

  // Verdict and end of run
  task automatic report_and_stop;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    rst_n = 1'b0; tc = 4'h0; tick = 4'h0;
    awa = 8'h0; wd = 32'h0; ws = 4'h0; awv = 1'b0; wv = 1'b0; bry = 1'b0;
    ara = 8'h0; arv = 1'b0; rry = 1'b0;
    failures = 0; n_tests = 0; irqs = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_count;
    t_stop;
    t_force;
    t_edges;
    t_zero;
    t_cks;
    t_out;
    report_and_stop;
  end

  // Watchdog, several times the expected run
  initial
  begin
    #400000;
    $display("[FAIL] watchdog expected finish seen timeout");
    failures++;
    report_and_stop;
  end
endmodule : eec_channel_tb_top
